/* File: epi_ctrl.sv */
// Purpose: eight level priority interrupt controller, top level
// Assumes: host strobes are one-cycle pulses on ref_clk
// Notes:   request lines are level sensitive and synchronised
`include "epi_defs.svh"
`default_nettype none
module epi_ctrl
  import epi_pkg::*;
#(
  parameter int LEVELS = 8
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [LEVELS-1:0] request_line,
  input  wire logic              bus_addr,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  input  wire logic [7:0]        bus_wdata,
  output logic      [7:0]        bus_rdata,
  input  wire logic              cpu_ack,
  output logic                   cpu_irq_input,
  output logic      [15:0]       vector_addr,
  output logic                   vector_valid
);

  // ****************************************************************
  // state
  // ****************************************************************
  epi_state_s st_q;
  epi_state_s st_d;

  epi_res_if rif ();

  // ****************************************************************
  // resolver hookup
  // ****************************************************************
  assign rif.pending_request_reg    = st_q.pending_request_reg;
  assign rif.in_service_reg    = st_q.in_service_reg;
  assign rif.mask   = st_q.mask;
  assign rif.lowest = st_q.lowest;
  assign rif.smm    = st_q.smm;
  assign rif.ready  = (st_q.init_st == EPI_INIT_READY);

  epi_resolver u_resolver (
    .rif (rif)
  );

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  logic       wr_cmd;
  logic       wr_data;
  logic       is_word_one;
  logic [1:0] op_sel;
  logic [2:0] op2_code;
  logic [2:0] op_level;
  logic       ack_take;
  logic [7:0] win_onehot;
  logic [7:0] isr_clr;
  logic [7:0] vec_low;

  function automatic logic [7:0] lvl_onehot(input logic [2:0] lvl);
    return 8'(8'h01 << lvl);
  endfunction : lvl_onehot

  always_comb begin
    wr_cmd      = bus_wr && (bus_addr == `EPI_ADDR_CMD);
    wr_data     = bus_wr && (bus_addr == `EPI_ADDR_DATA);
    is_word_one = bus_wdata[`EPI_W1_ID_BIT];
    op_sel      = bus_wdata[`EPI_OP_SEL_HI:`EPI_OP_SEL_LO];
    op2_code    = bus_wdata[`EPI_OP2_CODE_HI:`EPI_OP2_CODE_LO];
    op_level    = bus_wdata[2:0];
    // acknowledge only counts while the request is actually raised
    ack_take    = cpu_ack && st_q.irq;
    win_onehot  = lvl_onehot(rif.win_level);
  end

  // ****************************************************************
  // vector assembly
  // ****************************************************************
  always_comb begin
    if (st_q.word_one[`EPI_W1_FOUR_BIT]) begin
      // four byte spacing, 32 byte block, bit 5 from first word
      vec_low = {st_q.word_one[`EPI_W1_ADDR_HI:`EPI_W1_ADDR_LO],
                 rif.win_level, 2'b00};
    end else begin
      // eight byte spacing, 64 byte block, bit 5 from level
      vec_low = {st_q.word_one[`EPI_W1_ADDR_HI:`EPI_W1_ADDR_LO+1],
                 rif.win_level, 3'b000};
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d              = st_q;
    st_d.vector_valid = 1'b0;
    isr_clr           = 8'h00;

    // two flops on the pins before anything looks at them
    st_d.req_sync[0] = request_line;
    st_d.req_sync[1] = st_q.req_sync[0];
    // level sensitive pending bits follow the synchronised lines
    st_d.pending_request_reg = st_q.req_sync[1];

    // ---------------- command port ----------------
    if (wr_cmd && is_word_one) begin
      // first init word restarts the sequence and clears modes
      st_d.word_one = bus_wdata;
      st_d.init_st  = EPI_INIT_WORD2;
      st_d.in_service_reg      = 8'h00;
      st_d.mask     = `EPI_MASK_RST;
      st_d.lowest   = `EPI_LOWEST_RST;
      st_d.auto_rot = 1'b0;
      st_d.smm      = 1'b0;
      st_d.rd_isr   = 1'b0;
    end else if (wr_cmd && (st_q.init_st == EPI_INIT_READY)) begin
      if (op_sel == `EPI_OP_SEL_TWO) begin
        case (op2_code)
          `EPI_OP2_EOI: begin
            if (rif.top_found) begin
              isr_clr = lvl_onehot(rif.top_level);
              if (st_q.auto_rot) begin
                st_d.lowest = rif.top_level;
              end
            end
          end
          `EPI_OP2_ROT_EOI: begin
            st_d.auto_rot = 1'b1;
            if (rif.top_found) begin
              isr_clr     = lvl_onehot(rif.top_level);
              st_d.lowest = rif.top_level;
            end
          end
          `EPI_OP2_ROT_CLR: begin
            st_d.auto_rot = 1'b0;
          end
          `EPI_OP2_SPECIFIC_END_OF_SERVICE_CMD: begin
            isr_clr = lvl_onehot(op_level);
          end
          `EPI_OP2_SROT_EOI: begin
            isr_clr     = lvl_onehot(op_level);
            st_d.lowest = op_level;
          end
          `EPI_OP2_SET_PRI: begin
            st_d.lowest = op_level;
          end
          default: begin
            st_d.lowest = st_q.lowest;
          end
        endcase
      end else if (op_sel == `EPI_OP_SEL_THREE) begin
        if (bus_wdata[`EPI_OP3_RR_BIT]) begin
          st_d.rd_isr = bus_wdata[`EPI_OP3_RIS_BIT];
        end
        if (bus_wdata[`EPI_OP3_ESMM_BIT]) begin
          st_d.smm = bus_wdata[`EPI_OP3_SMM_BIT];
        end
      end
    end

    // ---------------- data port ----------------
    if (wr_data) begin
      if (st_q.init_st == EPI_INIT_WORD2) begin
        st_d.word_two = bus_wdata;
        // cascade and fourth word are not supported: ready at once
        st_d.init_st  = EPI_INIT_READY;
      end else if (st_q.init_st == EPI_INIT_READY) begin
        st_d.mask = bus_wdata;
      end
    end

    // ---------------- acknowledge ----------------
    // set after clear so a same-cycle acknowledge is never lost
    st_d.in_service_reg = st_d.in_service_reg & ~isr_clr;
    if (ack_take) begin
      st_d.in_service_reg          = st_d.in_service_reg | win_onehot;
      st_d.pending_request_reg          = st_d.pending_request_reg & ~win_onehot;
      st_d.vector       = {st_q.word_two, vec_low};
      st_d.vector_valid = 1'b1;
    end

    // ---------------- read back ----------------
    if (bus_rd) begin
      if (bus_addr == `EPI_ADDR_CMD) begin
        st_d.rdata = st_q.rd_isr ? st_q.in_service_reg : st_q.pending_request_reg;
      end else begin
        st_d.rdata = st_q.mask;
      end
    end

    // request drops the cycle after acknowledge to avoid a double take
    st_d.irq = rif.irq_req && !ack_take;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q.req_sync     <= '0;
      st_q.init_st      <= EPI_INIT_IDLE;
      st_q.word_one     <= `EPI_WORD_RST;
      st_q.word_two     <= `EPI_WORD_RST;
      st_q.pending_request_reg          <= 8'h00;
      st_q.in_service_reg          <= 8'h00;
      st_q.mask         <= `EPI_MASK_RST;
      st_q.lowest       <= `EPI_LOWEST_RST;
      st_q.auto_rot     <= 1'b0;
      st_q.smm          <= 1'b0;
      st_q.rd_isr       <= 1'b0;
      st_q.rdata        <= 8'h00;
      st_q.irq          <= 1'b0;
      st_q.vector       <= 16'h0000;
      st_q.vector_valid <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cpu_irq_input = st_q.irq;
  assign bus_rdata     = st_q.rdata;
  assign vector_addr   = st_q.vector;
  assign vector_valid  = st_q.vector_valid;

endmodule : epi_ctrl
`default_nettype wire

/* File: epi_defs.svh */
// Purpose: constants of the eight level priority interrupt controller
// Assumes: host bus and acknowledge are synchronous to ref_clk
// Notes:   offsets are the low address bit of the two-address window
//
// Function
// - eight request inputs, one combined processor request
// - request output wired straight to processor
// - higher unmasked request preempts; others stay pending
// - default fixed priority, line zero highest
// - after acknowledge, lower levels blocked, higher allowed
// - auto rotation: serviced level becomes lowest
// - auto rotation happens at end command
// - specific rotation: software names lowest, next highest
// - specific rotate end clears level, makes it lowest
// - set lowest level anytime without ending service
// - per-line mask bits, writable any time after init
// - masked in-service level still blocks lower levels
// - special mask mode unblocks lower levels until cleared by operation word three or first init word
// - pending and in-service registers readable by select
// - vectors spaced four or eight bytes
// - vector bits 0-4 inserted, 6-15 programmed
// - bit 5 from level or first word
// - first word: bits 5-7 address, bit 2 spacing
// - first word identified by bit 4; single bit
// - second word gives vector bits 8-15
// - two addresses; commands accepted after init
// - specific end command is 01100 plus level
// - specific rotate end is 11100 plus level
`ifndef EPI_DEFS_SVH
`define EPI_DEFS_SVH

`define EPI_ADDR_CMD      1'b0
`define EPI_ADDR_DATA     1'b1
`define EPI_SYNC_STAGES   2
// ****************************************************************
// first init word fields
// ****************************************************************
`define EPI_W1_ID_BIT     4
`define EPI_W1_SNGL_BIT   1
`define EPI_W1_FOUR_BIT   2
`define EPI_W1_ADDR_HI    7
`define EPI_W1_ADDR_LO    5
// ****************************************************************
// operation word selection and fields
// ****************************************************************
`define EPI_OP_SEL_HI     4
`define EPI_OP_SEL_LO     3
`define EPI_OP_SEL_TWO    2'h0
`define EPI_OP_SEL_THREE  2'h1
`define EPI_OP2_CODE_HI   7
`define EPI_OP2_CODE_LO   5
`define EPI_OP2_EOI       3'h1
`define EPI_OP2_SPECIFIC_END_OF_SERVICE_CMD      3'h3
`define EPI_OP2_ROT_CLR   3'h4
`define EPI_OP2_ROT_EOI   3'h5
`define EPI_OP2_SET_PRI   3'h6
`define EPI_OP2_SROT_EOI  3'h7
`define EPI_OP3_RR_BIT    1
`define EPI_OP3_RIS_BIT   0
`define EPI_OP3_SMM_BIT   5
`define EPI_OP3_ESMM_BIT  6
// ****************************************************************
// reset values
// ****************************************************************
`define EPI_LOWEST_RST    3'h7
`define EPI_MASK_RST      8'h00
`define EPI_WORD_RST      8'h00

`endif

/* File: epi_pkg.sv */
// Purpose: types and shared functions of the interrupt controller
// Assumes: eight levels
// Notes:   priority functions are used by the resolver only
`default_nettype none
package epi_pkg;

  typedef enum logic [1:0] {
    EPI_INIT_IDLE  = 2'b00,
    EPI_INIT_WORD2 = 2'b01,
    EPI_INIT_READY = 2'b10
  } epi_init_e;

  typedef struct packed {
    logic [1:0][7:0] req_sync;
    epi_init_e       init_st;
    logic [7:0]      word_one;
    logic [7:0]      word_two;
    logic [7:0]      pending_request_reg;
    logic [7:0]      in_service_reg;
    logic [7:0]      mask;
    logic [2:0]      lowest;
    logic            auto_rot;
    logic            smm;
    logic            rd_isr;
    logic [7:0]      rdata;
    logic            irq;
    logic [15:0]     vector;
    logic            vector_valid;
  } epi_state_s;

  // highest priority set bit, search starts just above lowest
  function automatic logic [3:0] epi_highest(input logic [7:0] bits,
                                             input logic [2:0] lowest);
    logic [3:0] res;
    logic [2:0] cand;
    res = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      cand = 3'(lowest + 3'h1 + 3'(i));
      if (bits[cand]) begin
        res = {1'b1, cand};
      end
    end
    return res;
  endfunction : epi_highest

  // zero is the top rank
  function automatic logic [2:0] epi_rank(input logic [2:0] level,
                                          input logic [2:0] lowest);
    return 3'(level - lowest - 3'h1);
  endfunction : epi_rank

endpackage : epi_pkg
`default_nettype wire

/* File: epi_res_if.sv */
// Purpose: carries state to the resolver and its verdict back
// Assumes: single clock, purely combinational path
// Notes:   none
`default_nettype none
interface epi_res_if;
  logic [7:0] pending_request_reg;
  logic [7:0] in_service_reg;
  logic [7:0] mask;
  logic [2:0] lowest;
  logic       smm;
  logic       ready;
  logic       irq_req;
  logic [2:0] win_level;
  logic       top_found;
  logic [2:0] top_level;

  modport ctrl (output pending_request_reg, in_service_reg, mask, lowest, smm, ready,
                input  irq_req, win_level, top_found, top_level);
  modport res  (input  pending_request_reg, in_service_reg, mask, lowest, smm, ready,
                output irq_req, win_level, top_found, top_level);
endinterface : epi_res_if
`default_nettype wire

/* File: epi_resolver.sv */
// Purpose: priority resolution of pending against in-service levels
// Assumes: inputs come from registers of the controller
// Notes:   combinational; the controller registers its outputs
`default_nettype none
module epi_resolver
  import epi_pkg::*;
(
  epi_res_if.res rif
);
  logic [7:0] blk_isr;
  logic [3:0] req_top;
  logic [3:0] blk_top;
  logic [3:0] isr_top;

  always_comb begin
    // special mask mode drops masked in-service levels from blocking
    blk_isr = rif.smm ? (rif.in_service_reg & ~rif.mask) : rif.in_service_reg;
    req_top = epi_highest(rif.pending_request_reg & ~rif.mask, rif.lowest);
    blk_top = epi_highest(blk_isr, rif.lowest);
    isr_top = epi_highest(rif.in_service_reg, rif.lowest);
    rif.win_level = req_top[2:0];
    rif.top_found = isr_top[3];
    rif.top_level = isr_top[2:0];
    rif.irq_req   = 1'b0;
    if (rif.ready && req_top[3]) begin
      if (!blk_top[3]) begin
        rif.irq_req = 1'b1;
      end else if (epi_rank(req_top[2:0], rif.lowest) <
                   epi_rank(blk_top[2:0], rif.lowest)) begin
        rif.irq_req = 1'b1;
      end
    end
  end

endmodule : epi_resolver
`default_nettype wire

/* File: epi_ctrl_chk.sv */
// Purpose: port checker of the interrupt controller
// Assumes: one clock, synchronous reset
// Notes:   bound from the bench top file
`default_nettype none
module epi_ctrl_chk #(
  parameter int LEVELS = 8
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [LEVELS-1:0] request_line,
  input wire logic              bus_addr,
  input wire logic              bus_wr,
  input wire logic              bus_rd,
  input wire logic [7:0]        bus_wdata,
  input wire logic [7:0]        bus_rdata,
  input wire logic              cpu_ack,
  input wire logic              cpu_irq_input,
  input wire logic [15:0]       vector_addr,
  input wire logic              vector_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire taken = cpu_ack && cpu_irq_input;
  // ****
  // acknowledge and vector
  // ****
  ack_vec_a: assert property (taken |=> vector_valid)
    else $error("no vector after acknowledge");
  stray_vec_a: assert property (!taken |=> !vector_valid)
    else $error("vector without acknowledge");
  vec_pulse_a: assert property (vector_valid |=> !vector_valid)
    else $error("vector strobe too long");
  irq_drop_a: assert property (vector_valid |-> !cpu_irq_input)
    else $error("request stayed up at vector");
  vec_hold_a: assert property (!vector_valid |-> $stable(vector_addr))
    else $error("vector moved without strobe");
  vec_low_a: assert property (vector_valid |-> vector_addr[1:0] == 2'h0)
    else $error("vector low bits not zero");
  // ****
  // status and request
  // ****
  rd_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  // four cycles: two sync flops, pending reg, irq reg
  irq_cause_a: assert property ($rose(cpu_irq_input) |-> |$past(request_line, 4))
    else $error("request raised with no line");
  cover property (taken);
  cover property (bus_rd ##1 bus_rdata != 8'h00);
  cover property (vector_valid ##[1:30] vector_valid);
endmodule : epi_ctrl_chk
`default_nettype wire

/* File: epi_host.sv */
// Purpose: host processor model, I/O bus and acknowledge
// Assumes: drives on the falling edge of ref_clk
// Notes:   ack lag set by the bench, 0 to 3 cycles
`default_nettype none
module epi_host (
  input  wire logic       ref_clk,
  input  wire logic       cpu_irq_input,
  input  wire logic [1:0] lag,
  output logic            bus_addr,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic [7:0]      bus_wdata,
  output logic            cpu_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q = 2'h0;
  initial begin
    {bus_addr, bus_wr, bus_rd, cpu_ack} = 4'h0;
    bus_wdata = 8'h00;
  end
  // one-cycle ack, only while the request is up
  always @(negedge ref_clk) begin
    wait_q <= cpu_irq_input ? wait_q + 2'h1 : 2'h0;
    cpu_ack <= cpu_irq_input && !cpu_ack && wait_q >= lag;
  end
  task automatic wr(input logic a, input logic [7:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge ref_clk);
    bus_wr = 1'b0;
    bus_wdata = ~d; // released data is not left valid
  endtask : wr
  task automatic rd(input logic a);
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge ref_clk);
    bus_rd = 1'b0;
  endtask : rd
endmodule : epi_host
`default_nettype wire

/* File: tb_epi_ctrl.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: host model drives bus and ack on falling edges
// Notes:   vectors and reads checked from queues
`default_nettype none
module tb_epi_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, bus_addr, bus_wr, bus_rd, cpu_ack, cpu_irq_input, vector_valid;
  logic [7:0]  request_line, bus_wdata, bus_rdata, w1, w2, pat;
  logic [15:0] vector_addr;
  logic [1:0]  lag;
  logic        rd_seen = 1'b0;
  logic [15:0] vq[$];
  logic [15:0] rq[$];
  int          errors, checks_done;
  epi_ctrl #(.LEVELS(8)) DUT (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .request_line  (request_line),
    .bus_addr      (bus_addr),
    .bus_wr        (bus_wr),
    .bus_rd        (bus_rd),
    .bus_wdata     (bus_wdata),
    .bus_rdata     (bus_rdata),
    .cpu_ack       (cpu_ack),
    .cpu_irq_input (cpu_irq_input),
    .vector_addr   (vector_addr),
    .vector_valid  (vector_valid)
  );
  epi_host host (
    .ref_clk       (ref_clk),
    .cpu_irq_input (cpu_irq_input),
    .lag           (lag),
    .bus_addr      (bus_addr),
    .bus_wr        (bus_wr),
    .bus_rd        (bus_rd),
    .bus_wdata     (bus_wdata),
    .cpu_ack       (cpu_ack)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ****
  // checking
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge ref_clk) rd_seen <= bus_rd;
  always @(negedge ref_clk) begin
    if (vector_valid === 1'b1) begin
      // a vector nobody asked for is a mismatch, never an unknown compare
      chk({15'h0000, vq.size() != 0}, 16'h0001);
      if (vq.size() != 0) chk(vector_addr, vq.pop_front());
    end
    if (rd_seen === 1'b1) chk({8'h00, bus_rdata}, rq.size() ? rq.pop_front() : 16'hFFFF);
  end
  function automatic logic [15:0] vec(input logic [2:0] l);
    return w1[2] ? {w2, w1[7:5], l, 2'h0} : {w2, w1[7:6], l, 3'h0};
  endfunction : vec
  // line dropped after service so level tracking cannot re-raise it
  task automatic serve(input logic [2:0] l);
    vq.push_back(vec(l));
    lag = 2'($urandom);
    for (int i = 0; i < 40 && vq.size() != 0; i++) @(negedge ref_clk);
    chk(16'(vq.size()), 16'h0000);
    vq.delete();
    request_line[l] = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : serve
  task automatic quiet();
    repeat (8) @(negedge ref_clk);
    chk({15'h0000, cpu_irq_input}, 16'h0000);
  endtask : quiet
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    #200000;
    errors++;
    final_report();
  end
  // ****
  // scenarios
  // ****
  initial begin
    {rst, request_line, lag, errors, checks_done} = {1'b1, 8'h00, 2'h0, 32'h0, 32'h0};
    void'($urandom(32'h182A));
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    request_line = 8'h01;
    quiet();
    request_line = 8'h00;
    quiet();
    for (int sp = 0; sp < 2; sp++) begin
      w1 = {3'($urandom), 2'h2, 1'(sp), 2'h2};
      w2 = 8'($urandom);
      host.wr(1'b0, w1);
      host.wr(1'b1, w2);
      host.wr(1'b1, 8'h00);
      pat = 8'($urandom) | 8'h81;
      request_line = pat;
      for (int l = 0; l < 8; l++) begin
        if (pat[l]) begin
          serve(3'(l));
          host.wr(1'b0, 8'h20);
        end
      end
    end
    request_line[5] = 1'b1;
    serve(3'h5);
    request_line[2] = 1'b1;
    serve(3'h2);
    request_line[7] = 1'b1;
    quiet();
    host.wr(1'b0, 8'h0B);
    rq.push_back(16'h0024);
    host.rd(1'b0);
    host.wr(1'b0, 8'h62);
    quiet();
    host.wr(1'b0, 8'h20);
    serve(3'h7);
    host.wr(1'b0, 8'h20);
    request_line = 8'h50;
    serve(3'h4);
    request_line[4] = 1'b1;
    repeat (4) @(negedge ref_clk);
    host.wr(1'b0, 8'hA0);
    serve(3'h6);
    host.wr(1'b0, 8'h20);
    serve(3'h4);
    host.wr(1'b0, 8'h20);
    host.wr(1'b0, 8'h80);
    host.wr(1'b0, 8'hC2);
    request_line = 8'h0A;
    serve(3'h3);
    request_line[3] = 1'b1;
    repeat (4) @(negedge ref_clk);
    host.wr(1'b0, 8'hE3);
    serve(3'h1);
    host.wr(1'b0, 8'h61);
    // line three is still up and now alone: serve it before moving on
    serve(3'h3);
    host.wr(1'b0, 8'h63);
    host.wr(1'b0, 8'hC7);
    request_line = 8'h04;
    serve(3'h2);
    host.wr(1'b1, 8'h04);
    request_line[5] = 1'b1;
    quiet();
    host.wr(1'b0, 8'h0A);
    rq.push_back(16'h0020);
    host.rd(1'b0);
    rq.push_back(16'h0004);
    host.rd(1'b1);
    host.wr(1'b0, 8'h68);
    serve(3'h5);
    host.wr(1'b0, 8'h48);
    host.wr(1'b0, 8'h65);
    host.wr(1'b0, 8'h62);
    repeat (4) @(negedge ref_clk);
    final_report();
  end
endmodule : tb_epi_ctrl
bind epi_ctrl epi_ctrl_chk #(.LEVELS(LEVELS)) chk (
  .ref_clk       (ref_clk),
  .rst           (rst),
  .request_line  (request_line),
  .bus_addr      (bus_addr),
  .bus_wr        (bus_wr),
  .bus_rd        (bus_rd),
  .bus_wdata     (bus_wdata),
  .bus_rdata     (bus_rdata),
  .cpu_ack       (cpu_ack),
  .cpu_irq_input (cpu_irq_input),
  .vector_addr   (vector_addr),
  .vector_valid  (vector_valid)
);
`default_nettype wire
